// file: dv/ams_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module ams_adc_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Converter pins
  input wire logic adc_start_i,
  input wire logic adc_chan_i,
  output logic [11:0] adc_data_o,
  output logic adc_done_o,
  // Knob positions and pace
  input wire logic [11:0] val_a_i,
  input wire logic [11:0] val_b_i,
  input wire logic slow_i
);
  logic pend[$];
  logic ch;
  int dly;
  // Queue start requests
  always @(posedge clk_i) begin
    if (rst_i) begin
      pend.delete();
    end else if (adc_start_i === 1'b1) begin
      pend.push_back(adc_chan_i);
    end
  end
  // One conversion at a time, prompt or slow
  initial begin
    adc_data_o = 12'h000;
    adc_done_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (pend.size() != 0) begin
        ch = pend.pop_front();
        dly = slow_i ? $urandom_range(12, 1) : 1;
        repeat (dly) @(posedge clk_i);
        adc_data_o <= ch ? val_b_i : val_a_i; // Selected knob
        @(posedge clk_i);
        adc_done_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        adc_done_o <= 1'b0;
        adc_data_o <= ~adc_data_o; // Released pins stop showing the value
      end
    end
  end
endmodule : ams_adc_model
`default_nettype wire

// file: dv/analog_input_speed_mixer_test.sv
`timescale 1ns/1ps
`default_nettype none
module analog_input_speed_mixer_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic slow = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_w = 32'h0000_0000;
  logic [11:0] va = 12'h800;
  logic [11:0] vb = 12'h800;
  logic [1:0] rc = 2'b00;
  logic [3:0] sel = 4'hF;
  logic ack, adc_start, adc_chan, adc_done, stop, sw;
  logic [31:0] dat_r, q;
  logic [11:0] adc_data;
  logic [1:0] pot, pull;
  logic [15:0] spd;
  int n_fail = 0;
  int checked = 0;
  int cyc_n = 0;

  ams_speed_mixer i_ams_speed_mixer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .adc_data_i(adc_data), .adc_done_i(adc_done), .adc_start_o(adc_start), .adc_chan_o(adc_chan),
    .rc_pulse_i(rc), .pot_supply_o(pot), .pullup_en_o(pull), .motor_speed_o(spd),
    .motor_stop_o(stop), .switch_active_o(sw));
  ams_adc_model i_ams_adc_model (.clk_i(clk_i), .rst_i(rst_i), .adc_start_i(adc_start),
    .adc_chan_i(adc_chan), .adc_data_o(adc_data), .adc_done_o(adc_done), .val_a_i(va),
    .val_b_i(vb), .slow_i(slow));

  // Clock and timeout
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic knobs(input logic [11:0] a, input logic [11:0] b);
    @(posedge clk_i);
    va <= a;
    vb <= b;
    repeat (120) @(posedge clk_i);
  endtask : knobs

  // Calibrated value with neutral 0x800, forward gain 0x1903, reverse gain 0x1000
  function automatic logic signed [31:0] cal(input logic [11:0] v);
    logic signed [31:0] d;
    d = $signed({20'h0_0000, v}) - 32'sh0000_0800;
    return d < 0 ? (d * 32'sh0000_1000) >>> 12 : (d * 32'sh0000_1903) >>> 12;
  endfunction : cal

  function automatic logic [31:0] mix_exp(input logic [11:0] a, input logic [11:0] b, input int m);
    logic signed [31:0] r;
    r = m == 1 ? cal(a) + cal(b) : m == 2 ? cal(a) - cal(b) : cal(a);
    r = r > 32'sh0000_0C80 ? 32'sh0000_0C80 : r < -32'sh0000_0C80 ? -32'sh0000_0C80 : r;
    return {16'h0000, r[15:0]};
  endfunction : mix_exp

  // Main sequence
  initial begin
    int s;
    logic [11:0] a, b;
    s = $urandom(57836);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("pot_supply", {30'h0, pot}, 32'h0000_0003);
    wb(0, ams_pkg::REG_CTRL, 0);
    chk("ctrl_rst", q, 32'h0000_0000);
    wb(0, ams_pkg::REG_CAL1_POS, 0);
    chk("cal_pos_rst", q, 32'h0FFF_0800);
    wb(0, ams_pkg::REG_RC_FWD, 0);
    chk("rc_fwd_rst", q, 32'h1F40_1F40);
    wb(1, ams_pkg::REG_CAL1_GAIN, 32'h1000_1903);
    wb(1, ams_pkg::REG_CAL2_GAIN, 32'h1000_1903);
    wb(0, ams_pkg::REG_CAL2_GAIN, 0);
    chk("gain_wr", q, 32'h1000_1903);
    // Low lanes only: neutral rewritten, forward untouched
    sel <= 4'h3;
    wb(1, ams_pkg::REG_CAL2_POS, 32'h0123_0800);
    sel <= 4'hF;
    wb(0, ams_pkg::REG_CAL2_POS, 0);
    chk("lane_wr", q, 32'h0FFF_0800);
    $display("test registers done");
    // Readings published outside analog mode, read-only and unmapped places
    a = 12'($urandom_range(4095, 17));
    b = 12'($urandom_range(4095, 17));
    knobs(a, b);
    wb(1, ams_pkg::REG_ANALOG, 32'hFFFF_FFFF);
    wb(1, 8'h40, 32'hFFFF_FFFF);
    wb(0, ams_pkg::REG_ANALOG, 0);
    chk("analog_rd", q, {4'h0, b, 4'h0, a});
    wb(0, 8'h40, 0);
    chk("unmapped", q, 32'h0000_0000);
    chk("speed_serial", {16'h0000, spd}, 32'h0000_0000);
    $display("test readings done");
    // Mixing with random and extreme positions
    for (int m = 0; m < 3; m++) begin
      wb(1, ams_pkg::REG_CTRL, 32'(1 + 4 * m));
      for (int i = 0; i < 6; i++) begin
        a = i == 0 ? 12'hFFF : 12'($urandom_range(4095, 17));
        b = i == 0 ? (m == 2 ? 12'h011 : 12'hFFF) : 12'($urandom_range(4095, 17));
        slow <= 1'($urandom_range(1, 0));
        knobs(a, b);
        chk("motor_speed", {16'h0000, spd}, mix_exp(a, b, m));
      end
    end
    $display("test mixing done");
    // Both analog channels as switches in serial mode, threshold 0xFFF >> 1
    wb(1, ams_pkg::REG_CTRL, 32'h0000_0180);
    for (int j = 0; j < 3; j++) begin
      knobs(12'(12'h7FF + (j == 1)), 12'(12'h7FF + (j == 2)));
      chk("switch", {30'h0, sw, stop}, 32'(j == 0 ? 0 : 3));
    end
    wb(0, ams_pkg::REG_STATUS, 0);
    chk("status", q, 32'h0009_0000);
    $display("test analog switch done");
    // Disconnection, its override and the pull-up
    wb(1, ams_pkg::REG_CTRL, 32'h0000_0001);
    knobs(12'h010, 12'h800);
    chk("disc_stop", {31'h0, stop}, 32'h0000_0001);
    knobs(12'h011, 12'h800);
    chk("disc_clear", {31'h0, stop}, 32'h0000_0000);
    wb(1, ams_pkg::REG_CTRL, 32'h0000_0011);
    knobs(12'h010, 12'h800);
    chk("disc_ignored", {31'h0, stop}, 32'h0000_0000);
    wb(1, ams_pkg::REG_CTRL, 32'h0000_0021);
    repeat (20) @(posedge clk_i);
    chk("pullup", {29'h0, pull, stop}, 32'h0000_0002);
    $display("test disconnect done");
    // Pulse channel as switch, forward 0x20 so the threshold is 16 ticks
    wb(1, ams_pkg::REG_RC_FWD, 32'h0020_0020);
    wb(1, ams_pkg::REG_CTRL, 32'h0000_0200);
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_i);
      rc <= 2'b11;
      repeat ((j ? 40 : 8) * ams_pkg::RC_TICK_CYC) @(posedge clk_i);
      rc <= 2'b00;
      repeat (30) @(posedge clk_i);
      wb(0, ams_pkg::REG_RC, 0);
      s = j ? 40 : 8;
      chk("rc_width", 32'(q[15:0] + 1 - s <= 2 && q[31:16] + 1 - s <= 2), 32'h0000_0001);
      chk("rc_switch", {31'h0, sw}, 32'(j));
    end
    $display("test pulse switch done");
    end_sim();
  end
endmodule : analog_input_speed_mixer_test
`default_nettype wire

// file: inc/ams_pkg.sv
package ams_pkg;
  // Widths
  localparam int ADC_W = 12;
  localparam int RC_W = 16;
  localparam int SPD_W = 16;
  localparam int PROD_W = 30;
  localparam int GAIN_SHIFT = 12;
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RC_RES_NS = 250;
  localparam int RC_TICK_CYC = RC_RES_NS / CLK_PERIOD_NS;
  localparam logic [2:0] RC_DIV_LAST = 3'(RC_TICK_CYC - 1);
  localparam int ADC_LSB_UV = 800;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CAL1_POS = 8'h04;
  localparam logic [7:0] REG_CAL1_GAIN = 8'h08;
  localparam logic [7:0] REG_CAL2_POS = 8'h0C;
  localparam logic [7:0] REG_CAL2_GAIN = 8'h10;
  localparam logic [7:0] REG_RC_FWD = 8'h14;
  localparam logic [7:0] REG_ANALOG = 8'h18;
  localparam logic [7:0] REG_RC = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MIX_LSB = 2;
  localparam int CTRL_IGN_BIT = 4;
  localparam int CTRL_PULLUP_LSB = 5;
  localparam int CTRL_SWEN_LSB = 7;
  localparam int HI_LSB = 16;
  localparam int ST_SW_BIT = 16;
  localparam int ST_DISC_LSB = 17;
  localparam int ST_STOP_BIT = 19;
  // Reset values and limits
  localparam logic [ADC_W-1:0] NEUTRAL_RST = 12'h800;
  localparam logic [ADC_W-1:0] FWD_RST = 12'hFFF;
  localparam logic [15:0] GAIN_RST = 16'h1903;
  localparam logic [RC_W-1:0] RC_FWD_RST = 16'h1F40;
  localparam logic [ADC_W-1:0] DISC_LO = 12'h010;
  localparam logic signed [PROD_W-1:0] SPD_MAX = 30'sh0000_0C80;
  localparam logic signed [SPD_W-1:0] SPD_LIM = 16'sh0C80;
  // Modes
  typedef enum logic [1:0] {MODE_SERIAL, MODE_ANALOG, MODE_RC} ams_mode_t;
  typedef enum logic [1:0] {MIX_OFF, MIX_LEFT, MIX_RIGHT} ams_mix_t;
endpackage : ams_pkg

// file: inc/ams_smp_if.sv
`timescale 1ns/1ps
`default_nettype none
// Latest readings of a channel pair
interface ams_smp_if #(parameter int W = 12);
  logic [W-1:0] ch_a;
  logic [W-1:0] ch_b;
  modport src(output ch_a, output ch_b);
  modport snk(input ch_a, input ch_b);
endinterface : ams_smp_if
`default_nettype wire

// file: verilog/ams_adc_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module ams_adc_sampler (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Converter pins
  input wire logic [ams_pkg::ADC_W-1:0] adc_data_i,
  input wire logic adc_done_i,
  output logic adc_start_o,
  output logic adc_chan_o,
  // Readings
  ams_smp_if.src smp
);
  typedef enum logic {SMP_START, SMP_WAIT} ams_smp_state_t;
  ams_smp_state_t state, next_state;
  logic [ams_pkg::ADC_W-1:0] data_m, data_s, next_a, next_b;
  logic done_m, done_s, done_d, next_start, next_chan;

  // Alternate channels, capture on converter done edge
  always_comb begin
    next_state = state;
    next_start = 1'b0;
    next_chan = adc_chan_o;
    next_a = smp.ch_a;
    next_b = smp.ch_b;
    case (state)
      SMP_START: begin
        next_start = 1'b1;
        next_state = SMP_WAIT;
      end
      SMP_WAIT: begin
        if (done_s && !done_d) begin
          if (adc_chan_o) begin
            next_b = data_s;
          end else begin
            next_a = data_s;
          end
          next_chan = ~adc_chan_o;
          next_state = SMP_START;
        end
      end
      default: next_state = SMP_START;
    endcase
  end

  // Synchronisers and state
  always_ff @(posedge clk_i) begin
    data_m <= adc_data_i;
    data_s <= data_m;
    done_m <= adc_done_i;
    done_s <= done_m;
    done_d <= done_s;
    if (rst_i) begin
      state <= SMP_START;
      adc_start_o <= 1'b0;
      adc_chan_o <= 1'b0;
      smp.ch_a <= '0;
      smp.ch_b <= '0;
    end else begin
      state <= next_state;
      adc_start_o <= next_start;
      adc_chan_o <= next_chan;
      smp.ch_a <= next_a;
      smp.ch_b <= next_b;
    end
  end

  sequence seq_capture;
    state == SMP_WAIT && done_s && !done_d;
  endsequence
  chk_sample_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_capture |=> (adc_chan_o != $past(adc_chan_o)) ##1 adc_start_o ##1 !adc_start_o)
    else $error("sampler did not move to the next channel");
endmodule : ams_adc_sampler
`default_nettype wire

// file: verilog/ams_rc_capture.sv
`timescale 1ns/1ps
`default_nettype none
module ams_rc_capture (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pulse pins
  input wire logic [1:0] rc_pulse_i,
  // Widths
  ams_smp_if.src smp
);
  logic [1:0] rc_m, rc_s, rc_d;
  logic [2:0] div, next_div;
  logic tick, next_tick;
  logic [ams_pkg::RC_W-1:0] cnt [0:1];
  logic [ams_pkg::RC_W-1:0] next_cnt [0:1];
  logic [ams_pkg::RC_W-1:0] next_w [0:1];

  // Quarter microsecond tick, count high time, publish on fall
  always_comb begin
    next_div = div + 3'h1;
    next_tick = 1'b0;
    if (div == ams_pkg::RC_DIV_LAST) begin
      next_div = '0;
      next_tick = 1'b1;
    end
    next_w[0] = smp.ch_a;
    next_w[1] = smp.ch_b;
    for (int k = 0; k < 2; k++) begin
      next_cnt[k] = cnt[k];
      if (rc_s[k] && tick && (cnt[k] != '1)) begin
        next_cnt[k] = cnt[k] + 16'h0001;
      end
      if (rc_d[k] && !rc_s[k]) begin
        next_w[k] = cnt[k];
        next_cnt[k] = '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    rc_m <= rc_pulse_i;
    rc_s <= rc_m;
    rc_d <= rc_s;
    if (rst_i) begin
      div <= '0;
      tick <= 1'b0;
      cnt[0] <= '0;
      cnt[1] <= '0;
      smp.ch_a <= '0;
      smp.ch_b <= '0;
    end else begin
      div <= next_div;
      tick <= next_tick;
      cnt <= next_cnt;
      smp.ch_a <= next_w[0];
      smp.ch_b <= next_w[1];
    end
  end

  chk_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
    tick |=> !tick [*4] ##1 tick)
    else $error("quarter microsecond tick spacing wrong");
endmodule : ams_rc_capture
`default_nettype wire

// file: verilog/ams_speed_mixer.sv
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module ams_speed_mixer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog converter
  input wire logic [ams_pkg::ADC_W-1:0] adc_data_i,
  input wire logic adc_done_i,
  output logic adc_start_o,
  output logic adc_chan_o,
  // RC pulses
  input wire logic [1:0] rc_pulse_i,
  // Pot supply and pull-ups
  output logic [1:0] pot_supply_o,
  output logic [1:0] pullup_en_o,
  // Motor
  output logic [ams_pkg::SPD_W-1:0] motor_speed_o,
  output logic motor_stop_o,
  output logic switch_active_o
);
  ams_smp_if #(.W(ams_pkg::ADC_W)) adc_bus();
  ams_smp_if #(.W(ams_pkg::RC_W)) rc_bus();

  ams_adc_sampler u_adc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .adc_data_i(adc_data_i),
    .adc_done_i(adc_done_i),
    .adc_start_o(adc_start_o),
    .adc_chan_o(adc_chan_o),
    .smp(adc_bus)
  );

  ams_rc_capture u_rc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rc_pulse_i(rc_pulse_i),
    .smp(rc_bus)
  );

  // Byte-lane merge of a write
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // Clamp to full reverse .. full forward
  function automatic logic signed [ams_pkg::SPD_W-1:0] sat(input logic signed [ams_pkg::PROD_W-1:0] x);
    logic signed [ams_pkg::PROD_W-1:0] y;
    y = x;
    if (x > ams_pkg::SPD_MAX) begin
      y = ams_pkg::SPD_MAX;
    end else if (x < -ams_pkg::SPD_MAX) begin
      y = -ams_pkg::SPD_MAX;
    end
    return y[ams_pkg::SPD_W-1:0];
  endfunction : sat

  // Neutral to zero, one extreme full forward, other full reverse
  function automatic logic signed [ams_pkg::SPD_W-1:0] cal_map(input logic [ams_pkg::ADC_W-1:0] v,
      input logic [ams_pkg::ADC_W-1:0] neu, input logic [15:0] gf, input logic [15:0] gr);
    logic signed [ams_pkg::ADC_W:0] diff;
    logic signed [ams_pkg::PROD_W-1:0] prod;
    diff = $signed({1'b0, v}) - $signed({1'b0, neu});
    prod = diff * $signed({1'b0, (diff < 0) ? gr : gf});
    return sat(prod >>> ams_pkg::GAIN_SHIFT);
  endfunction : cal_map

  // Configuration state
  ams_pkg::ams_mode_t mode, next_mode;
  ams_pkg::ams_mix_t mix, next_mix;
  logic ign_disc, next_ign;
  logic [3:0] sw_en, next_sw_en;
  logic [ams_pkg::ADC_W-1:0] cal_neu [0:1];
  logic [ams_pkg::ADC_W-1:0] cal_fwd [0:1];
  logic [15:0] gain_f [0:1];
  logic [15:0] gain_r [0:1];
  logic [ams_pkg::RC_W-1:0] rc_fwd [0:1];
  logic [ams_pkg::ADC_W-1:0] next_neu [0:1];
  logic [ams_pkg::ADC_W-1:0] next_fwd [0:1];
  logic [15:0] next_gf [0:1];
  logic [15:0] next_gr [0:1];
  logic [ams_pkg::RC_W-1:0] next_rc_fwd [0:1];
  logic [1:0] next_pullup;
  logic next_ack;
  logic [31:0] next_dat, ctrl_word, rdata, w;
  logic [1:0] disc;

  assign ctrl_word = {21'h00_0000, sw_en, pullup_en_o, ign_disc, mix, mode};

  // Register read view
  always_comb begin
    case (wb_adr_i)
      ams_pkg::REG_CTRL: rdata = ctrl_word;
      ams_pkg::REG_CAL1_POS: rdata = {4'h0, cal_fwd[0], 4'h0, cal_neu[0]};
      ams_pkg::REG_CAL1_GAIN: rdata = {gain_r[0], gain_f[0]};
      ams_pkg::REG_CAL2_POS: rdata = {4'h0, cal_fwd[1], 4'h0, cal_neu[1]};
      ams_pkg::REG_CAL2_GAIN: rdata = {gain_r[1], gain_f[1]};
      ams_pkg::REG_RC_FWD: rdata = {rc_fwd[1], rc_fwd[0]};
      ams_pkg::REG_ANALOG: rdata = {4'h0, adc_bus.ch_b, 4'h0, adc_bus.ch_a};
      ams_pkg::REG_RC: rdata = {rc_bus.ch_b, rc_bus.ch_a};
      ams_pkg::REG_STATUS: rdata = {12'h000, motor_stop_o, disc, switch_active_o, motor_speed_o};
      default: rdata = '0;
    endcase
  end

  // Bus slave: answer one cycle after strobe, writes merged by lane
  always_comb begin
    next_mode = mode;
    next_mix = mix;
    next_ign = ign_disc;
    next_sw_en = sw_en;
    next_pullup = pullup_en_o;
    next_neu = cal_neu;
    next_fwd = cal_fwd;
    next_gf = gain_f;
    next_gr = gain_r;
    next_rc_fwd = rc_fwd;
    next_ack = 1'b0;
    next_dat = '0;
    w = '0;
    if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      next_ack = 1'b1;
      if (!wb_we_i) begin
        next_dat = rdata;
      end else begin
        w = lane_merge(rdata, wb_dat_i, wb_sel_i);
        case (wb_adr_i)
          ams_pkg::REG_CTRL: begin
            next_mode = ams_pkg::ams_mode_t'(w[ams_pkg::CTRL_MODE_LSB +: 2]);
            next_mix = ams_pkg::ams_mix_t'(w[ams_pkg::CTRL_MIX_LSB +: 2]);
            next_ign = w[ams_pkg::CTRL_IGN_BIT];
            next_pullup = w[ams_pkg::CTRL_PULLUP_LSB +: 2];
            next_sw_en = w[ams_pkg::CTRL_SWEN_LSB +: 4];
          end
          ams_pkg::REG_CAL1_POS: begin
            next_neu[0] = w[ams_pkg::ADC_W-1:0];
            next_fwd[0] = w[ams_pkg::HI_LSB +: ams_pkg::ADC_W];
          end
          ams_pkg::REG_CAL1_GAIN: begin
            next_gf[0] = w[15:0];
            next_gr[0] = w[ams_pkg::HI_LSB +: 16];
          end
          ams_pkg::REG_CAL2_POS: begin
            next_neu[1] = w[ams_pkg::ADC_W-1:0];
            next_fwd[1] = w[ams_pkg::HI_LSB +: ams_pkg::ADC_W];
          end
          ams_pkg::REG_CAL2_GAIN: begin
            next_gf[1] = w[15:0];
            next_gr[1] = w[ams_pkg::HI_LSB +: 16];
          end
          ams_pkg::REG_RC_FWD: begin
            next_rc_fwd[0] = w[ams_pkg::RC_W-1:0];
            next_rc_fwd[1] = w[ams_pkg::HI_LSB +: ams_pkg::RC_W];
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= ams_pkg::MODE_SERIAL;
      mix <= ams_pkg::MIX_OFF;
      ign_disc <= 1'b0;
      sw_en <= '0;
      pullup_en_o <= '0;
      pot_supply_o <= '1;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      for (int i = 0; i < 2; i++) begin
        cal_neu[i] <= ams_pkg::NEUTRAL_RST;
        cal_fwd[i] <= ams_pkg::FWD_RST;
        gain_f[i] <= ams_pkg::GAIN_RST;
        gain_r[i] <= ams_pkg::GAIN_RST;
        rc_fwd[i] <= ams_pkg::RC_FWD_RST;
      end
    end else begin
      mode <= next_mode;
      mix <= next_mix;
      ign_disc <= next_ign;
      sw_en <= next_sw_en;
      pullup_en_o <= next_pullup;
      pot_supply_o <= '1;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      cal_neu <= next_neu;
      cal_fwd <= next_fwd;
      gain_f <= next_gf;
      gain_r <= next_gr;
      rc_fwd <= next_rc_fwd;
    end
  end

  // Speed path state
  logic signed [ams_pkg::SPD_W-1:0] cal_thr, cal_str, next_thr, next_str, mixed;
  logic [ams_pkg::RC_W-1:0] sw_val [0:3];
  logic [ams_pkg::RC_W-1:0] sw_fwd [0:3];
  logic [3:0] next_sw;
  logic [1:0] next_disc;
  logic kill, next_stop;
  logic [ams_pkg::SPD_W-1:0] next_speed;

  assign sw_val[0] = {4'h0, adc_bus.ch_a};
  assign sw_val[1] = {4'h0, adc_bus.ch_b};
  assign sw_val[2] = rc_bus.ch_a;
  assign sw_val[3] = rc_bus.ch_b;
  assign sw_fwd[0] = {4'h0, cal_fwd[0]};
  assign sw_fwd[1] = {4'h0, cal_fwd[1]};
  assign sw_fwd[2] = rc_fwd[0];
  assign sw_fwd[3] = rc_fwd[1];
  assign kill = switch_active_o || (|disc);

  // Calibrate, detect switches and lost pots, mix
  always_comb begin
    next_thr = cal_map(adc_bus.ch_a, cal_neu[0], gain_f[0], gain_r[0]);
    next_str = cal_map(adc_bus.ch_b, cal_neu[1], gain_f[1], gain_r[1]);
    next_sw = '0;
    for (int k = 0; k < 4; k++) begin
      next_sw[k] = sw_en[k] && (sw_val[k] > (sw_fwd[k] >> 1));
    end
    for (int i = 0; i < 2; i++) begin
      // Only a low reading is a lost pot; a lost return reads high
      next_disc[i] = !ign_disc && !pullup_en_o[i] && (adc_bus.ch_a <= ams_pkg::DISC_LO);
    end
    next_disc[1] = !ign_disc && !pullup_en_o[1] && (adc_bus.ch_b <= ams_pkg::DISC_LO);
    case (mix)
      ams_pkg::MIX_LEFT: mixed = sat(ams_pkg::PROD_W'(cal_thr) + ams_pkg::PROD_W'(cal_str));
      ams_pkg::MIX_RIGHT: mixed = sat(ams_pkg::PROD_W'(cal_thr) - ams_pkg::PROD_W'(cal_str));
      default: mixed = cal_thr;
    endcase
    next_stop = kill;
    next_speed = (mode == ams_pkg::MODE_ANALOG && !kill) ? mixed : '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_thr <= '0;
      cal_str <= '0;
      switch_active_o <= 1'b0;
      disc <= '0;
      motor_stop_o <= 1'b0;
      motor_speed_o <= '0;
    end else begin
      cal_thr <= next_thr;
      cal_str <= next_str;
      switch_active_o <= |next_sw;
      disc <= next_disc;
      motor_stop_o <= next_stop;
      motor_speed_o <= next_speed;
    end
  end

  // Checks
  logic signed [ams_pkg::SPD_W:0] sum_raw, dif_raw;
  assign sum_raw = {cal_thr[ams_pkg::SPD_W-1], cal_thr} + {cal_str[ams_pkg::SPD_W-1], cal_str};
  assign dif_raw = {cal_thr[ams_pkg::SPD_W-1], cal_thr} - {cal_str[ams_pkg::SPD_W-1], cal_str};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_disc_seen;
    disc[0] ##1 motor_stop_o && motor_speed_o == '0;
  endsequence

  chk_nomix_first: assert property (
    (mode == ams_pkg::MODE_ANALOG && mix == ams_pkg::MIX_OFF && !kill) |=> motor_speed_o == $past(cal_thr))
    else $error("unmixed speed not from throttle channel");
  chk_mix_left: assert property (
    (mode == ams_pkg::MODE_ANALOG && mix == ams_pkg::MIX_LEFT && !kill && sum_raw <= ams_pkg::SPD_LIM
     && sum_raw >= -ams_pkg::SPD_LIM) |=> $signed(motor_speed_o) == $past(sum_raw))
    else $error("left mix not the sum");
  chk_mix_right: assert property (
    (mode == ams_pkg::MODE_ANALOG && mix == ams_pkg::MIX_RIGHT && !kill && dif_raw <= ams_pkg::SPD_LIM
     && dif_raw >= -ams_pkg::SPD_LIM) |=> $signed(motor_speed_o) == $past(dif_raw))
    else $error("right mix not the difference");
  chk_speed_range: assert property (
    $signed(motor_speed_o) <= ams_pkg::SPD_LIM && $signed(motor_speed_o) >= -ams_pkg::SPD_LIM)
    else $error("speed beyond full scale");
  chk_switch_stop: assert property (
    switch_active_o |=> motor_stop_o && motor_speed_o == '0)
    else $error("active switch did not stop motor");
  chk_switch_thresh: assert property (
    (sw_en[0] && {4'h0, adc_bus.ch_a} > ({4'h0, cal_fwd[0]} >> 1)) |=> switch_active_o)
    else $error("analog switch above half forward not active");
  chk_rc_switch: assert property (
    (sw_en[2] && rc_bus.ch_a > (rc_fwd[0] >> 1)) |=> switch_active_o)
    else $error("rc switch above half forward not active");
  chk_disc_ignore: assert property (
    ign_disc |=> disc == '0)
    else $error("disconnect flagged while ignored");
  chk_disc_stop: assert property (
    (!ign_disc && !pullup_en_o[0] && adc_bus.ch_a <= ams_pkg::DISC_LO) |=> seq_disc_seen)
    else $error("lost pot did not stop motor");
  chk_mode_idle: assert property (
    mode != ams_pkg::MODE_ANALOG |=> motor_speed_o == '0)
    else $error("speed driven outside analog mode");
endmodule : ams_speed_mixer
`default_nettype wire
